// *** core/scaler_pixel_dword_packer.sv ***
// Purpose: packs scaled pixels into 32-bit words for the first video FIFO
// Assumes: one pixel per handshake, pix_last marks the last of a line
// Notes: registers over AXI4-Lite; one word per handshake at most, two when a line end splits
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module scaler_pixel_dword_packer (
   input wire logic clock,
   input wire logic rst,
   input wire logic [packer_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [packer_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pix_valid,
   output logic pix_ready,
   input wire logic pix_last,
   input wire logic [7:0] pix_y_r,
   input wire logic [7:0] pix_u_g,
   input wire logic [7:0] pix_v_b,
   input wire logic pix_key,
   input wire logic [7:0] pix_alpha,
   output logic [31:0] fifo1_data,
   input wire logic fifo1_ready,
   output logic fifo1_valid
);
   import packer_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge

   function automatic logic [31:0] swap_word(input logic [31:0] w,
         input swap_t s);
      unique case (s)
         SWAP_2B: swap_word = {w[23:16], w[31:24], w[7:0], w[15:8]};
         SWAP_4B: swap_word = {w[7:0], w[15:8], w[23:16], w[31:24]};
         default: swap_word = w;
      endcase
   endfunction : swap_word

   // returns {new error, dithered value}; sub-block truncates low bits
   function automatic logic [10:0] quant(input logic [7:0] c,
         input logic [2:0] e, input logic [2:0] drop, input logic en);
      logic [8:0] s;
      logic [7:0] v, m;
      s = en ? ({1'b0, c} + {6'h00, e}) : {1'b0, c};
      v = s[8] ? 8'hFF : s[7:0];
      m = 8'((9'h001 << drop) - 9'h001);
      quant = {3'(v & m), v};
   endfunction : quant

   // register file and bus state
   wr_state_t wr_st_ff, nxt_wr_st;
   logic [31:0] ctrl_ff, base_ff, wdata_ff;
   logic [3:0] wstrb_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [15:0] words_ff, lines_ff;
   logic aw_hs, w_hs, wr_go;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   // packing state
   logic [31:0] acc_ff, flush_word_ff, out_ff;
   logic [1:0] pos_ff;
   logic line_start_ff, flush_ff, out_valid_ff, pix_ready_ff;
   logic [2:0] idx_ff, r_err_ff, g_err_ff, b_err_ff;
   logic [7:0] v_hold_ff;

   fmt_t fmt;
   swap_t swap;
   logic alpha_sel, dither_en, accept, slot_free, full, emit, flush_set;
   logic nxt_out_valid, nxt_flush;
   logic [1:0] start_pos, pos_now;
   logic [2:0] total, e_r, e_g, e_b, drop_g;
   logic [31:0] acc_now, pb_bytes;
   logic [63:0] win;
   logic [2:0] pb_cnt;
   logic [7:0] pb_v;
   logic [10:0] q_r, q_g, q_b;
   logic [7:0] in0, in1, in2;

   assign fmt = fmt_t'(ctrl_ff[CTRL_FMT_LSB +: 3]);
   assign swap = swap_t'(ctrl_ff[CTRL_SWAP_LSB +: 2]);
   assign alpha_sel = ctrl_ff[CTRL_ALPHA_BIT];
   // error diffusion only makes sense where bits are dropped
   assign dither_en = ctrl_ff[CTRL_DITHER_BIT] &&
      (fmt inside {FMT_RGB565, FMT_RGB1555, FMT_RGB5515});

   assign aw_hs = s_axi_awvalid && awready_ff;
   assign w_hs = s_axi_wvalid && wready_ff;
   assign wr_addr = (wr_st_ff == WR_HAVE_ADDR) ? awaddr_ff : s_axi_awaddr;
   assign wr_data = (wr_st_ff == WR_HAVE_DATA) ? wdata_ff : s_axi_wdata;
   assign wr_strb = (wr_st_ff == WR_HAVE_DATA) ? wstrb_ff : s_axi_wstrb;

   always_comb begin
      nxt_wr_st = wr_st_ff;
      wr_go = 1'b0;
      unique case (wr_st_ff)
         WR_IDLE: begin
            if (aw_hs && w_hs) begin
               nxt_wr_st = WR_RESP;
               wr_go = 1'b1;
            end else if (aw_hs) begin
               nxt_wr_st = WR_HAVE_ADDR;
            end else if (w_hs) begin
               nxt_wr_st = WR_HAVE_DATA;
            end
         end
         WR_HAVE_ADDR: begin
            if (w_hs) begin
               nxt_wr_st = WR_RESP;
               wr_go = 1'b1;
            end
         end
         WR_HAVE_DATA: begin
            if (aw_hs) begin
               nxt_wr_st = WR_RESP;
               wr_go = 1'b1;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               nxt_wr_st = WR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_st_ff <= WR_IDLE;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end else begin
         wr_st_ff <= nxt_wr_st;
         awready_ff <= nxt_wr_st inside {WR_IDLE, WR_HAVE_DATA};
         wready_ff <= nxt_wr_st inside {WR_IDLE, WR_HAVE_ADDR};
         bvalid_ff <= nxt_wr_st == WR_RESP;
         if (aw_hs) awaddr_ff <= s_axi_awaddr;
         if (w_hs) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            bresp_ff <= (wr_addr == ADDR_CTRL || wr_addr == ADDR_BASE ||
               wr_addr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // format and swap are held steady across a field by software
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_ff <= CTRL_RESET;
         base_ff <= BASE_RESET;
      end else if (wr_go && wr_addr == ADDR_CTRL) begin
         ctrl_ff <= merge(ctrl_ff, wr_data, wr_strb);
      end else if (wr_go && wr_addr == ADDR_BASE) begin
         base_ff <= merge(base_ff, wr_data, wr_strb);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rresp_ff <= RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_CTRL: rdata_ff <= ctrl_ff;
            ADDR_BASE: rdata_ff <= base_ff;
            ADDR_STATUS: rdata_ff <= {lines_ff, words_ff};
            default: begin
               rdata_ff <= '0;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   always_comb begin
      unique case (fmt)
         FMT_RGB565, FMT_RGB1555, FMT_RGB5515:
            start_pos = {base_ff[1], 1'b0};
         FMT_RGB24, FMT_YUV422, FMT_YUV411:
            start_pos = base_ff[1:0];
         default: start_pos = 2'b00;
      endcase
   end

   assign e_r = line_start_ff ? 3'h0 : r_err_ff;
   assign e_g = line_start_ff ? 3'h0 : g_err_ff;
   assign e_b = line_start_ff ? 3'h0 : b_err_ff;
   assign drop_g = (fmt == FMT_RGB565) ? DROP_6BIT : DROP_5BIT;
   assign q_r = quant(pix_y_r, e_r, DROP_5BIT, dither_en);
   assign q_g = quant(pix_u_g, e_g, drop_g, dither_en);
   assign q_b = quant(pix_v_b, e_b, DROP_5BIT, dither_en);
   assign in0 = q_r[7:0];
   assign in1 = q_g[7:0];
   assign in2 = q_b[7:0];

   pixel_bytes u_pixel_bytes (
      .fmt(fmt),
      .alpha_sel(alpha_sel),
      .idx(idx_ff),
      .c0(in0),
      .c1(in1),
      .c2(in2),
      .key(pix_key),
      .alpha(pix_alpha),
      .v_hold(v_hold_ff),
      .bytes(pb_bytes),
      .cnt(pb_cnt),
      .v_now(pb_v)
   );

   // byte lanes fill from the low end; a word leaves when four are full
   assign accept = pix_valid && pix_ready_ff;
   assign slot_free = !out_valid_ff || fifo1_ready;
   assign pos_now = line_start_ff ? start_pos : pos_ff;
   assign acc_now = line_start_ff ? 32'h0 : acc_ff;
   assign win = {32'h0, acc_now} |
      ({32'h0, pb_bytes} << {pos_now, 3'b000});
   assign total = {1'b0, pos_now} + pb_cnt;
   assign full = total[2];
   assign emit = accept && (full || (pix_last && total[1:0] != 2'b00));
   assign flush_set = accept && pix_last && full &&
      total[1:0] != 2'b00;
   assign nxt_flush = (flush_ff && !slot_free) || flush_set;
   assign nxt_out_valid = emit || (flush_ff && slot_free) ||
      (out_valid_ff && !fifo1_ready);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc_ff <= '0;
         pos_ff <= '0;
         line_start_ff <= 1'b1;
         idx_ff <= '0;
         v_hold_ff <= C_ZERO;
         r_err_ff <= '0;
         g_err_ff <= '0;
         b_err_ff <= '0;
      end else if (accept) begin
         acc_ff <= full ? win[63:32] : win[31:0];
         pos_ff <= total[1:0];
         line_start_ff <= pix_last;
         idx_ff <= pix_last ? 3'h0 : idx_ff + 3'h1;
         if (!idx_ff[0]) v_hold_ff <= pb_v;
         r_err_ff <= q_r[10:8];
         g_err_ff <= q_g[10:8];
         b_err_ff <= q_b[10:8];
      end
   end

   // one output slot; the pixel side waits on it, trading rate for area
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_ff <= '0;
         out_valid_ff <= 1'b0;
         flush_ff <= 1'b0;
         flush_word_ff <= '0;
         pix_ready_ff <= 1'b0;
      end else begin
         out_valid_ff <= nxt_out_valid;
         flush_ff <= nxt_flush;
         if (flush_set) flush_word_ff <= win[63:32];
         if (emit) begin
            out_ff <= swap_word(win[31:0], swap);
         end else if (flush_ff && slot_free) begin
            out_ff <= swap_word(flush_word_ff, swap);
         end
         pix_ready_ff <= ctrl_ff[CTRL_ENABLE_BIT] && !nxt_out_valid &&
            !nxt_flush;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         words_ff <= '0;
         lines_ff <= '0;
      end else begin
         if (out_valid_ff && fifo1_ready) words_ff <= words_ff + 16'h1;
         if (accept && pix_last) lines_ff <= lines_ff + 16'h1;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign pix_ready = pix_ready_ff;
   assign fifo1_data = out_ff;
   assign fifo1_valid = out_valid_ff;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // first word of a split line end leaves while the tail waits
   sequence flush_waiting;
      flush_ff && out_valid_ff && fifo1_ready;
   endsequence

   a_out_hold: assert property (out_valid_ff && !fifo1_ready |=>
      out_valid_ff && $stable(out_ff)) else $error("word dropped");
   a_flush_sent: assert property (flush_waiting |=>
      out_valid_ff && !flush_ff &&
      out_ff == swap_word($past(flush_word_ff), swap))
      else $error("flush word not sent");
   a_line_end: assert property (accept && pix_last &&
      total[1:0] != 2'b00 |=> out_valid_ff) else $error("line tail lost");
   a_argb_word: assert property (accept && fmt == FMT_ARGB32 &&
      swap == SWAP_NONE && !alpha_sel |=> out_ff == {{8{$past(pix_key)}},
      $past(pix_y_r), $past(pix_u_g), $past(pix_v_b)})
      else $error("keyed word wrong");
   a_swap_four: assert property (accept && fmt == FMT_ARGB32 &&
      swap == SWAP_4B |=> out_ff[7:0] == $past(pix_alpha) || !alpha_sel)
      else $error("byte reversal wrong");
   a_rgb24_count: assert property (fmt == FMT_RGB24 |->
      pb_cnt == CNT_24BPP) else $error("24-bit count wrong");
   a_rgb16_count: assert property (accept && dither_en |->
      pb_cnt == CNT_16BPP) else $error("16-bit count wrong");
   a_luma_range: assert property (fmt == FMT_YUV422 |->
      pb_bytes[15:8] >= Y_BLACK && pb_bytes[15:8] <= Y_WHITE)
      else $error("luma out of range");
   a_chroma_range: assert property (fmt == FMT_YUV422 |->
      pb_v >= C_ZERO - C_SPAN && pb_v <= C_ZERO + C_SPAN)
      else $error("chroma out of range");
   a_phase_start: assert property (accept && line_start_ff &&
      fmt == FMT_RGB24 |-> pos_now == base_ff[1:0])
      else $error("line phase wrong");
   a_ready_slot: assert property (pix_ready_ff |-> !out_valid_ff &&
      !flush_ff) else $error("ready while slot busy");
endmodule : scaler_pixel_dword_packer

// *** core/packer_pkg.sv ***
// Purpose: shared constants and types for the pixel word packer
// Assumes: AXI4-Lite register port with 32-bit data
// Notes: byte addresses are word aligned
package packer_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BASE = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam int CTRL_FMT_LSB = 0;
   localparam int CTRL_SWAP_LSB = 3;
   localparam int CTRL_ALPHA_BIT = 5;
   localparam int CTRL_DITHER_BIT = 6;
   localparam int CTRL_ENABLE_BIT = 7;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [2:0] CNT_NONE = 3'h0;
   localparam logic [2:0] CNT_8BPP = 3'h1;
   localparam logic [2:0] CNT_16BPP = 3'h2;
   localparam logic [2:0] CNT_24BPP = 3'h3;
   localparam logic [2:0] CNT_32BPP = 3'h4;
   localparam logic [2:0] DROP_5BIT = 3'h3;
   localparam logic [2:0] DROP_6BIT = 3'h2;
   localparam int R5_LSB = 3;
   localparam int G6_LSB = 2;
   localparam logic [7:0] Y_BLACK = 8'h10;
   localparam logic [7:0] Y_WHITE = 8'hEB;
   localparam logic [7:0] C_ZERO = 8'h80;
   localparam logic [7:0] C_SPAN = 8'h70;
   typedef enum logic [2:0] {
      FMT_ARGB32 = 3'h0, FMT_RGB24 = 3'h1, FMT_RGB565 = 3'h2,
      FMT_RGB1555 = 3'h3, FMT_RGB5515 = 3'h4, FMT_YUV422 = 3'h5,
      FMT_YUV411 = 3'h6
   } fmt_t;
   typedef enum logic [1:0] {
      SWAP_NONE = 2'h0, SWAP_2B = 2'h1, SWAP_4B = 2'h2
   } swap_t;
   typedef enum logic [1:0] {
      WR_IDLE = 2'b00, WR_HAVE_ADDR = 2'b01, WR_RESP = 2'b11,
      WR_HAVE_DATA = 2'b10
   } wr_state_t;
endpackage : packer_pkg

// *** core/pixel_bytes.sv ***
// Purpose: turns one scaled pixel into its bytes for the chosen format
// Assumes: components arrive already quantised or dithered as needed
// Notes: bytes are listed from the high lane downward
`timescale 1ns/1ps
module pixel_bytes (
   input wire packer_pkg::fmt_t fmt,
   input wire logic alpha_sel,
   input wire logic [2:0] idx,
   input wire logic [7:0] c0,
   input wire logic [7:0] c1,
   input wire logic [7:0] c2,
   input wire logic key,
   input wire logic [7:0] alpha,
   input wire logic [7:0] v_hold,
   output logic [31:0] bytes,
   output logic [2:0] cnt,
   output logic [7:0] v_now
);
   import packer_pkg::*;

   function automatic logic [7:0] clampf(input logic [7:0] x,
         input logic [7:0] lo, input logic [7:0] hi);
      clampf = (x < lo) ? lo : ((x > hi) ? hi : x);
   endfunction : clampf

   logic [7:0] y, u, key8, chroma;

   always_comb begin
      y = clampf(c0, Y_BLACK, Y_WHITE);
      u = clampf(c1, C_ZERO - C_SPAN, C_ZERO + C_SPAN);
      v_now = clampf(c2, C_ZERO - C_SPAN, C_ZERO + C_SPAN);
      key8 = alpha_sel ? alpha : {8{key}};
      // chroma pair belongs to the first pixel of its group
      chroma = idx[0] ? v_hold : u;
      bytes = '0;
      cnt = CNT_NONE;
      unique case (fmt)
         FMT_ARGB32: begin
            // full range, components pass untouched
            bytes = {key8, c0, c1, c2};
            cnt = CNT_32BPP;
         end
         FMT_RGB24: begin
            bytes = {8'h00, c0, c1, c2};
            cnt = CNT_24BPP;
         end
         FMT_RGB565: begin
            bytes = {16'h0000, c0[7:R5_LSB], c1[7:G6_LSB],
               c2[7:R5_LSB]};
            cnt = CNT_16BPP;
         end
         FMT_RGB1555: begin
            bytes = {16'h0000, key, c0[7:R5_LSB], c1[7:R5_LSB],
               c2[7:R5_LSB]};
            cnt = CNT_16BPP;
         end
         FMT_RGB5515: begin
            bytes = {16'h0000, c0[7:R5_LSB], c1[7:R5_LSB], key,
               c2[7:R5_LSB]};
            cnt = CNT_16BPP;
         end
         FMT_YUV422: begin
            bytes = {16'h0000, y, chroma};
            cnt = CNT_16BPP;
         end
         FMT_YUV411: begin
            // chroma rides on pixels 0,1 of each group of four
            if (idx[1]) begin
               bytes = {24'h000000, y};
               cnt = CNT_8BPP;
            end else begin
               bytes = {16'h0000, y, chroma};
               cnt = CNT_16BPP;
            end
         end
         default: begin
            bytes = '0;
            cnt = CNT_NONE;
         end
      endcase
   end
endmodule : pixel_bytes

// *** sim/fifo_sink.sv ***
// Purpose: far side of video fifo one, taking packed words
// Assumes: a word moves at an edge with valid and ready both high
// Notes: slow mode stalls at random but never drops a word
`timescale 1ns/1ps
module fifo_sink (
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   output logic fifo1_ready
);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fifo1_ready <= 1'b0;
      end else begin
         // random back-pressure keeps the output slot full for a while
         fifo1_ready <= !slow || ($urandom % 3 == 0);
      end
   end
endmodule : fifo_sink

// *** sim/scaler_pixel_dword_packer_bench.sv ***
// Purpose: self-checking bench for the pixel word packer
// Assumes: fifo_sink is the far side; bready and rready stay high
// Notes: expected words queue up, a monitor pops one per moved word
`timescale 1ns/1ps
module scaler_pixel_dword_packer_bench;
   import packer_pkg::*;
   logic clock, rst, slow, pix_valid, pix_ready, pix_last, pix_key;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, fifo1_ready, fifo1_valid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, fifo1_data, w;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] pix_y_r, pix_u_g, pix_v_b, pix_alpha;
   logic [7:0] c0[8], c1[8], c2[8], al[8];
   logic [7:0] d0, d1, d2;
   logic kk[8];
   logic [31:0] exp_q[$];
   int failures, tests_run, words, lines;
   fmt_t f;
   scaler_pixel_dword_packer i_scaler_pixel_dword_packer (
      .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pix_valid, .pix_ready, .pix_last,
      .pix_y_r, .pix_u_g, .pix_v_b, .pix_key, .pix_alpha, .fifo1_data,
      .fifo1_ready, .fifo1_valid);
   fifo_sink i_fifo_sink (.clock, .rst, .slow, .fifo1_ready);
   task automatic bad(input string m);
      failures++;
      $display("mismatch at %0t: %s", $time, m);
   endtask : bad
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) bad($sformatf("got %h want %h", got, want));
   endtask : chk
   task automatic end_sim();
      if (exp_q.size() != 0) bad("words missing");
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
      chk(s_axi_rdata, d);
   endtask : rd
   task automatic cfg(input fmt_t fm, input swap_t s, input logic a,
         input logic [1:0] ph);
      wr(ADDR_BASE, {30'h0, ph}, RESP_OKAY);
      wr(ADDR_CTRL, {24'h0, 1'b1, 1'b0, a, s, fm}, RESP_OKAY);
   endtask : cfg
   task automatic fill(input logic yuv);
      for (int i = 0; i < 8; i++) begin
         c0[i] = yuv ? 8'(16 + $urandom % 220) : 8'($urandom);
         c1[i] = yuv ? 8'(16 + $urandom % 225) : 8'($urandom);
         c2[i] = yuv ? 8'(16 + $urandom % 225) : 8'($urandom);
         kk[i] = 1'($urandom);
         al[i] = 8'($urandom);
      end
   endtask : fill
   // valid stays up between pixels so a line goes back to back
   task automatic send(input int n);
      int t;
      for (int i = 0; i < n; i++) begin
         pix_valid <= 1'b1;
         pix_y_r <= c0[i];
         pix_u_g <= c1[i];
         pix_v_b <= c2[i];
         pix_key <= kk[i];
         pix_alpha <= al[i];
         pix_last <= (i == n - 1);
         t = 0;
         do begin
            @(posedge clock);
            t++;
         end while (pix_ready !== 1'b1 && t < 200);
      end
      pix_valid <= 1'b0;
      lines++;
   endtask : send
   task automatic done();
      int t;
      t = 0;
      while (exp_q.size() != 0 && t < 500) begin
         @(posedge clock);
         t++;
      end
      repeat (2) @(posedge clock);
   endtask : done
   function automatic logic [31:0] sw2(input logic [31:0] x);
      return {x[23:16], x[31:24], x[7:0], x[15:8]};
   endfunction : sw2
   function automatic logic [15:0] h16(input fmt_t fm, input int i);
      case (fm)
         FMT_RGB565: return {c0[i][7:3], c1[i][7:2], c2[i][7:3]};
         FMT_RGB1555:
            return {kk[i], c0[i][7:3], c1[i][7:3], c2[i][7:3]};
         default:
            return {c0[i][7:3], c1[i][7:3], kk[i], c2[i][7:3]};
      endcase
   endfunction : h16
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #200000;
      bad("watchdog");
      end_sim();
   end
   always @(posedge clock) begin
      if (fifo1_valid === 1'b1 && fifo1_ready === 1'b1) begin
         words++;
         if (exp_q.size() == 0) bad("stray word");
         else chk(fifo1_data, exp_q.pop_front());
      end
   end
   initial begin
      {rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
      {slow, pix_valid, pix_last, pix_key, pix_alpha} = 12'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {pix_y_r, pix_u_g, pix_v_b} = 24'h0;
      {failures, tests_run, words, lines} = 128'h0;
      void'($urandom(32'h8D88));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
      rd(ADDR_BASE, BASE_RESET, RESP_OKAY);
      rd(8'h0C, 32'h0, RESP_SLVERR);
      wr(8'h0C, 32'hFFFF_FFFF, RESP_SLVERR);
      for (int j = 0; j < 4; j++) begin
         fill(1'b0);
         cfg(FMT_ARGB32, swap_t'({j[1], 1'b0}), j[0], 2'h2);
         w = {j[0] ? al[0] : {8{kk[0]}}, c0[0], c1[0], c2[0]};
         if (j[1]) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
         exp_q.push_back(w);
         send(1);
         done();
      end
      rd(ADDR_CTRL, 32'h0000_00B0, RESP_OKAY);
      slow <= 1'b1;
      fill(1'b0);
      cfg(FMT_RGB24, SWAP_NONE, 1'b0, 2'h0);
      exp_q.push_back({c2[1], c0[0], c1[0], c2[0]});
      exp_q.push_back({c1[2], c2[2], c0[1], c1[1]});
      exp_q.push_back({c0[3], c1[3], c2[3], c0[2]});
      send(4);
      done();
      cfg(FMT_RGB24, SWAP_NONE, 1'b0, 2'h2);
      exp_q.push_back({c1[0], c2[0], 16'h0});
      exp_q.push_back({24'h0, c0[0]});
      send(1);
      done();
      slow <= 1'b0;
      for (int j = 0; j < 3; j++) begin
         f = fmt_t'(j + 2);
         fill(1'b0);
         cfg(f, swap_t'(j == 0), 1'b0, 2'h0);
         w = {h16(f, 1), h16(f, 0)};
         exp_q.push_back(j == 0 ? sw2(w) : w);
         w = {16'h0, h16(f, 2)};
         exp_q.push_back(j == 0 ? sw2(w) : w);
         send(3);
         done();
      end
      cfg(FMT_RGB565, SWAP_NONE, 1'b0, 2'h2);
      exp_q.push_back({h16(FMT_RGB565, 0), 16'h0});
      send(1);
      done();
      cfg(FMT_RGB565, SWAP_NONE, 1'b0, 2'h0);
      // dither on: low bits dropped from one pixel ride on the next
      wr(ADDR_CTRL, {24'h0, 2'b11, 3'h0, FMT_RGB565}, RESP_OKAY);
      d0 = (c0[1] > 8'hFF - c0[0][2:0]) ? 8'hFF : c0[1] + c0[0][2:0];
      d1 = (c1[1] > 8'hFF - c1[0][1:0]) ? 8'hFF : c1[1] + c1[0][1:0];
      d2 = (c2[1] > 8'hFF - c2[0][2:0]) ? 8'hFF : c2[1] + c2[0][2:0];
      exp_q.push_back({d0[7:3], d1[7:2], d2[7:3],
         h16(FMT_RGB565, 0)});
      send(2);
      done();
      // illegal format code makes no bytes, so no word may leave
      cfg(fmt_t'(3'h7), SWAP_NONE, 1'b0, 2'h0);
      send(1);
      done();
      fill(1'b1);
      {c0[0], c0[1], c1[0], c2[0]} = 32'h00FF_00FF;
      cfg(FMT_YUV422, SWAP_NONE, 1'b0, 2'h0);
      exp_q.push_back({Y_WHITE, C_ZERO + C_SPAN, Y_BLACK,
         C_ZERO - C_SPAN});
      exp_q.push_back({c0[3], c2[2], c0[2], c1[2]});
      send(4);
      done();
      slow <= 1'b1;
      fill(1'b1);
      cfg(FMT_YUV411, SWAP_NONE, 1'b0, 2'h0);
      exp_q.push_back({c0[1], c2[0], c0[0], c1[0]});
      exp_q.push_back({c0[4], c1[4], c0[3], c0[2]});
      exp_q.push_back({c0[7], c0[6], c0[5], c2[4]});
      send(8);
      done();
      rd(ADDR_STATUS, {16'(lines), 16'(words)}, RESP_OKAY);
      end_sim();
   end
endmodule : scaler_pixel_dword_packer_bench
